// >>> design/stc_pkg.sv
// shared constants of the sixteen-bit timer/counter
package stc_pkg;

  // bus geometry
  localparam int          ADR_W     = 10;
  localparam int          IDX_LSB   = 2;
  localparam int          IDX_W     = 8;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_INTCTL  = 8'h0B;
  localparam logic [7:0]  IDX_PFLAGS  = 8'h0C;
  localparam logic [7:0]  IDX_CNT_LO  = 8'h0E;
  localparam logic [7:0]  IDX_CNT_HI  = 8'h0F;
  localparam logic [7:0]  IDX_CTRL    = 8'h10;
  localparam logic [7:0]  IDX_PEN     = 8'h8C;
  localparam logic [7:0]  IDX_IRQ_ST  = 8'h20;
  localparam logic [7:0]  IDX_IRQ_MSK = 8'h21;

  // counter_control fields
  localparam int          CTL_RUN     = 0;
  localparam int          CTL_SRC     = 1;
  localparam int          CTL_BYP     = 2;
  localparam int          CTL_OSC     = 3;
  localparam int          CTL_PS_LO   = 4;
  localparam int          CTL_PS_HI   = 5;
  localparam int          CTL_GATE    = 6;
  localparam logic [7:0]  CTL_MASK    = 8'h7F;

  // interrupt_control, peripheral flags and enables
  localparam int          ICT_GIE     = 7;
  localparam int          ICT_PERIPHERAL_IRQ_ENABLE    = 6;
  localparam int          PF_OVF      = 0;
  localparam int          PE_OVF      = 0;
  localparam logic [7:0]  PF_MASK     = 8'h01;
  localparam logic [7:0]  PE_MASK     = 8'h01;

  // sticky event status bits
  localparam int          EV_W        = 2;
  localparam int          EV_OVF      = 0;
  localparam int          EV_WAKE     = 1;

  // reset values
  localparam logic [7:0]  RST_CTRL    = 8'h00;
  localparam logic [7:0]  RST_INTCTL  = 8'h00;
  localparam logic [7:0]  RST_PFLAGS  = 8'h00;
  localparam logic [7:0]  RST_PEN     = 8'h00;
  localparam logic [7:0]  RST_CNT     = 8'h00;
  localparam logic [1:0]  RST_EV      = 2'h0;

  // instruction clock is the core clock divided by four
  localparam logic [1:0]  QDIV_LAST   = 2'h3;
  localparam logic [15:0] CNT_TOP     = 16'hFFFF;

  // synchroniser lane order
  localparam int          SY_W        = 4;
  localparam int          SY_ECK      = 0;
  localparam int          SY_GATE     = 1;
  localparam int          SY_PA4      = 2;
  localparam int          SY_PA5      = 3;

endpackage : stc_pkg

// >>> design/stc_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module stc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // async levels in, synchronised levels out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // first stage feeds the second stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule // stc_sync

// >>> design/stc_timer.sv
// sixteen-bit timer/counter with prescaler, gate, crystal control and wishbone slave
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
// What this block does
// RL1 - count is two read/write bytes, low at 0Eh, high at 0Fh
// RL2 - counter advances only while the run bit 0 is set, else holds
// RL3 - sync bypass bit 2 lets the external clock count without phase alignment
// RL4 - unsynchronised counter mode keeps counting while the core sleeps
// RL5 - unsynchronised overflow can raise interrupt and wake the sleeping core
// RL6 - each count byte read returns a valid value; two reads not atomic
// RL7 - software stops the counter before writing a new count
// RL8 - oscillator enable bit 3 turns on the crystal oscillator between its pins
// RL9 - crystal oscillator is low power, up to 32 kHz, runs during sleep
// RL10 - crystal usable only while the system clock comes from the internal oscillator
// RL11 - software enables the oscillator and waits before starting the counter
// RL12 - oscillator on forces port directions 5,4 to read one, pins zero
// RL13 - during sleep only the unsynchronised external mode counts
// RL14 - wake needs counter running, overflow enable and peripheral enable set; wake_req_o does not check the run bit, it follows ovf_flag instead
// RL15 - on overflow wake with global enable set, branch to service routine
// RL16 - source bit picks external rising edges or quarter-rate internal clock
// RL17 - prescale field bits 5:4 divide by 1, 2, 4 or 8
// RL18 - gate enable with run counts only while the gate pin is low
module stc_timer
  import stc_pkg::*;
(
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone classic slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // core status
  input  wire logic             sleep_i,
  input  wire logic             sys_clk_internal_i,
  // pins
  input  wire logic             ext_count_clock_pin_i,
  input  wire logic             gate_input_pin_i,
  input  wire logic             port_a_pin_5_i,
  input  wire logic             port_a_pin_4_i,
  // port direction latch bits from the port block
  input  wire logic             port_a_direction_5_i,
  input  wire logic             port_a_direction_4_i,
  // port views seen by the core
  output logic                  port_a_direction_5_o,
  output logic                  port_a_direction_4_o,
  output logic                  port_a_pin_5_o,
  output logic                  port_a_pin_4_o,
  // crystal oscillator control
  output logic                  crystal_osc_enable_o,
  // core interrupt and wake requests
  output logic                  wake_req_o,
  output logic                  isr_branch_o,
  output logic                  irq_o
);

  // registers
  logic [7:0]      ctrl;
  logic [7:0]      intctl;
  logic            ovf_flag;
  logic            ovf_ie;
  logic [15:0]     count;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_mask;

  // timing state
  logic [1:0]      qdiv;
  logic [2:0]      pre;
  logic            eck_prev;
  logic            eck_pend;
  logic [SY_W-1:0] sy;

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  // lanes placed by the package indices, so the order cannot drift
  wire [SY_W-1:0] pin_lanes;
  assign pin_lanes[SY_ECK]  = ext_count_clock_pin_i;
  assign pin_lanes[SY_GATE] = gate_input_pin_i;
  assign pin_lanes[SY_PA4]  = port_a_pin_4_i;
  assign pin_lanes[SY_PA5]  = port_a_pin_5_i;

  stc_sync #(
    .W (SY_W)
  ) stc_sync_i (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (pin_lanes),
    .q_o   (sy)
  );

  wire gate_s = sy[SY_GATE];
  wire pa5_s  = sy[SY_PA5];
  wire pa4_s  = sy[SY_PA4];

  // ------------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------------
  wire       run      = ctrl[CTL_RUN];
  wire       src_ext  = ctrl[CTL_SRC];
  wire       bypass   = ctrl[CTL_BYP];
  wire       osc_on   = ctrl[CTL_OSC];
  wire [1:0] ps_sel   = {ctrl[CTL_PS_HI], ctrl[CTL_PS_LO]};
  wire       gate_en  = ctrl[CTL_GATE];
  wire       global_irq_enable      = intctl[ICT_GIE];
  wire       peripheral_irq_enable     = intctl[ICT_PERIPHERAL_IRQ_ENABLE];

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire [IDX_W-1:0] idx = adr_i[ADR_W-1:IDX_LSB];
  wire             req = cyc_i & stb_i;
  // first edge of a request; the ack then blocks a second take
  wire             take = req & ~ack_o;
  // write lands on the edge the master samples ack
  wire             wr  = req & we_i & ack_o & sel_i[0];
  wire [7:0]       wd  = dat_i[7:0];

  wire hit_intctl  = idx == IDX_INTCTL;
  wire hit_pflags  = idx == IDX_PFLAGS;
  wire hit_cnt_lo  = idx == IDX_CNT_LO;
  wire hit_cnt_hi  = idx == IDX_CNT_HI;
  wire hit_ctrl    = idx == IDX_CTRL;
  wire hit_pen     = idx == IDX_PEN;
  wire hit_irq_st  = idx == IDX_IRQ_ST;
  wire hit_irq_msk = idx == IDX_IRQ_MSK;

  wire wr_intctl  = wr & hit_intctl;
  wire wr_pflags  = wr & hit_pflags;
  wire wr_cnt_lo  = wr & hit_cnt_lo;  // [RL1]
  wire wr_cnt_hi  = wr & hit_cnt_hi;  // [RL1]
  wire wr_ctrl    = wr & hit_ctrl;
  wire wr_pen     = wr & hit_pen;
  wire wr_irq_st  = wr & hit_irq_st;
  wire wr_irq_msk = wr & hit_irq_msk;

  // ------------------------------------------------------------------
  // clock sources
  // ------------------------------------------------------------------
  // instruction-rate enable, one pulse every four core clocks
  wire q_en = qdiv == QDIV_LAST;  // [RL16]

  wire eck_s    = sy[SY_ECK];
  wire eck_rise = eck_s & ~eck_prev;  // [RL16]

  // synchronised mode releases a caught edge only on the instruction phase;
  // bypass mode counts the edge at once, trading phase alignment for sleep use
  wire sync_tick = (eck_rise | eck_pend) & q_en;
  wire ext_tick  = bypass ? eck_rise : sync_tick;  // [RL3]
  wire src_tick  = src_ext ? ext_tick : q_en;      // [RL16]

  // only the bypassed external source survives sleep; the internal phases stop
  wire async_mode = src_ext & bypass;                     // [RL4]
  wire sleep_ok   = ~sleep_i | async_mode;                // [RL13]
  wire gate_open  = ~(gate_en & run) | ~gate_s;           // [RL18]
  wire cnt_enable = run & sleep_ok & gate_open;           // [RL2]

  // prescaler divides by 1, 2, 4 or 8
  wire [2:0] pre_last =
    (ps_sel == 2'h0) ? 3'h0 :
    (ps_sel == 2'h1) ? 3'h1 :
    (ps_sel == 2'h2) ? 3'h3 : 3'h7;                       // [RL17]

  wire pre_step = src_tick & cnt_enable;
  wire inc      = pre_step & (pre >= pre_last);           // [RL17]
  wire cnt_wr   = wr_cnt_lo | wr_cnt_hi;

  // a count write wins over a coincident increment; the other byte may
  // still be stale, which is why software stops the counter first
  wire overflow = inc & ~cnt_wr & (count == CNT_TOP);     // [RL7]

  // ------------------------------------------------------------------
  // interrupt and wake logic
  // ------------------------------------------------------------------
  wire wake_cond  = ovf_flag & ovf_ie & peripheral_irq_enable;             // [RL14]
  wire wake_event = overflow & sleep_i & ovf_ie & peripheral_irq_enable;   // [RL5]

  wire [EV_W-1:0] ev_set;
  assign ev_set[EV_OVF]  = overflow;
  assign ev_set[EV_WAKE] = wake_event;

  // a clear and a new event in one cycle: the event wins
  wire [EV_W-1:0] ev_clr     = wr_irq_st ? wd[EV_W-1:0] : RST_EV;
  wire [EV_W-1:0] ev_pending = (ev_status | ev_set) & ev_mask;
  wire            isr_cond   = wake_cond & global_irq_enable;                   // [RL15]

  // ------------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------------
  wire [7:0] rd_pflags = {7'h00, ovf_flag};
  wire [7:0] rd_pen    = {7'h00, ovf_ie};
  wire [7:0] rd_irq_st = {{(8-EV_W){1'b0}}, ev_status};
  wire [7:0] rd_irq_mk = {{(8-EV_W){1'b0}}, ev_mask};

  // every byte is a settled flop, so a read never sees a half-updated byte
  wire [7:0] rd_byte =
    hit_intctl  ? intctl             :
    hit_pflags  ? rd_pflags          :
    hit_cnt_lo  ? count[7:0]         :   // [RL6]
    hit_cnt_hi  ? count[15:8]        :   // [RL6]
    hit_ctrl    ? (ctrl & CTL_MASK)  :
    hit_pen     ? rd_pen             :
    hit_irq_st  ? rd_irq_st          :
    hit_irq_msk ? rd_irq_mk          : 8'h00;
  wire [31:0] rd_word = {24'h00_0000, rd_byte};

  // ------------------------------------------------------------------
  // bus slave: ack one cycle after the request, data with it
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= take;
      if (take) begin
        dat_o <= rd_word;
      end
    end
  end

  // ------------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl    <= RST_CTRL;
      intctl  <= RST_INTCTL;
      ovf_ie  <= RST_PEN[PE_OVF];
      ev_mask <= RST_EV;
    end else begin
      if (wr_ctrl) begin
        ctrl <= wd & CTL_MASK;
      end
      if (wr_intctl) begin
        intctl <= wd;
      end
      if (wr_pen) begin
        ovf_ie <= wd[PE_OVF];
      end
      if (wr_irq_msk) begin
        ev_mask <= wd[EV_W-1:0];
      end
    end
  end

  // ------------------------------------------------------------------
  // flags: hardware set wins over a software clear in the same cycle
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovf_flag  <= RST_PFLAGS[PF_OVF];
      ev_status <= RST_EV;
    end else begin
      if (overflow) begin
        ovf_flag <= 1'b1;                                 // [RL5]
      end else if (wr_pflags) begin
        ovf_flag <= wd[PF_OVF];
      end
      ev_status <= (ev_status & ~ev_clr) | ev_set;
    end
  end

  // ------------------------------------------------------------------
  // clock dividers and edge tracking
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      qdiv     <= 2'h0;
      eck_prev <= 1'b0;
      eck_pend <= 1'b0;
    end else begin
      // internal phases halt while the core sleeps; q_en may rest high then,
      // harmless because no mode that reads it counts in sleep
      if (!sleep_i) begin
        qdiv <= qdiv + 2'h1;
      end
      eck_prev <= eck_s;
      if (q_en) begin
        eck_pend <= 1'b0;
      end else if (eck_rise) begin
        eck_pend <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------------
  // prescaler and sixteen-bit count
  // ------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre   <= 3'h0;
      count <= {RST_CNT, RST_CNT};
    end else begin
      if (cnt_wr) begin
        // a count write also restarts the prescaler
        pre <= 3'h0;
      end else if (inc) begin
        pre <= 3'h0;
      end else if (pre_step) begin
        pre <= pre + 3'h1;                                // [RL17]
      end
      if (wr_cnt_lo) begin
        count[7:0] <= wd;                                 // [RL1]
      end
      if (wr_cnt_hi) begin
        count[15:8] <= wd;                                // [RL1]
      end
      if (inc & ~cnt_wr) begin
        count <= count + 16'h0001;                        // [RL2]
      end
    end
  end

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------
  // oscillator stays on in sleep; it is shared with the system low-power
  // oscillator, so it is only granted while the core runs from internal
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      crystal_osc_enable_o <= 1'b0;
      port_a_direction_5_o <= 1'b0;
      port_a_direction_4_o <= 1'b0;
      port_a_pin_5_o       <= 1'b0;
      port_a_pin_4_o       <= 1'b0;
      wake_req_o           <= 1'b0;
      isr_branch_o         <= 1'b0;
      irq_o                <= 1'b0;
    end else begin
      crystal_osc_enable_o <= osc_on & sys_clk_internal_i;                 // [RL8] [RL9] [RL10]
      port_a_direction_5_o <= osc_on | port_a_direction_5_i;               // [RL12]
      port_a_direction_4_o <= osc_on | port_a_direction_4_i;               // [RL12]
      port_a_pin_5_o       <= ~osc_on & pa5_s;                             // [RL12]
      port_a_pin_4_o       <= ~osc_on & pa4_s;                             // [RL12]
      wake_req_o           <= wake_cond;                                   // [RL14]
      isr_branch_o         <= isr_cond;                                    // [RL15]
      irq_o                <= |ev_pending;
    end
  end

endmodule // stc_timer

// >>> tb/stc_pin_model.sv
// external count clock source sending bursts of rising edges
`timescale 1ns/1ps
module stc_pin_model (
  // clock and burst request
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] n_i,
  // pin and status
  output logic            pin_o,
  output logic            busy_o
);
  logic [7:0] left = 8'h00;
  logic [2:0] ph   = 3'h0;
  // four clocks high, four low, so the pin synchroniser sees every edge
  always @(posedge clk_i) begin
    if (go_i) begin
      left <= n_i;
      ph   <= 3'h0;
    end else if (left != 8'h00) begin
      ph <= ph + 3'h1;
      if (ph == 3'h7) left <= left - 8'h01;
    end
  end
  // pin stands low between bursts
  assign pin_o  = (left != 8'h00) && !ph[2];
  assign busy_o = left != 8'h00;
endmodule // stc_pin_model

// >>> tb/stc_timer_checker.sv
// assertion checker on the timer/counter ports
`timescale 1ns/1ps
module stc_timer_checker (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  input wire logic        sys_clk_internal_i,
  input wire logic        crystal_osc_enable_o,
  input wire logic        port_a_direction_5_o,
  input wire logic        port_a_direction_4_o,
  input wire logic        port_a_pin_5_o,
  input wire logic        port_a_pin_4_o,
  input wire logic        wake_req_o,
  input wire logic        isr_branch_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_ACK_PULSE: assert property (ack_o |=> !ack_o)
    else $error("ack held past one cycle");
  AST_ACK_LAT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("ack not one cycle after request");
  AST_DAT_HIGH: assert property (ack_o |-> dat_o[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  AST_DAT_HOLD: assert property (!(cyc_i && stb_i) |=> $stable(dat_o))
    else $error("read data changed without request");
  AST_OSC_SRC: assert property (crystal_osc_enable_o |-> $past(sys_clk_internal_i))
    else $error("crystal on without internal system clock");
  AST_OSC_PORT: assert property (crystal_osc_enable_o && $past(crystal_osc_enable_o) |->
    port_a_direction_5_o && port_a_direction_4_o && !port_a_pin_5_o && !port_a_pin_4_o)
    else $error("port views not forced while crystal on");
  AST_ISR_WAKE: assert property (isr_branch_o |-> wake_req_o)
    else $error("service branch without wake");
  AST_IRQ_STICKY: assert property (irq_o && !(cyc_i && stb_i && we_i) &&
    !$past(cyc_i && stb_i && we_i) |=> irq_o)
    else $error("interrupt dropped without a write");
endmodule // stc_timer_checker

// >>> tb/stc_timer_bench.sv
// self-checking bench for the sixteen-bit timer/counter
`timescale 1ns/1ps
module stc_timer_bench;
  import stc_pkg::*;
  localparam logic [23:0] ROWS [9] = '{{IDX_CTRL, 8'h80, 8'h00}, {IDX_CTRL, 8'h74, 8'h74},
    {IDX_CTRL, 8'h00, 8'h00}, {IDX_CNT_LO, 8'hA5, 8'hA5}, {IDX_CNT_HI, 8'h5A, 8'h5A}, {IDX_PEN, 8'hFF, 8'h01},
    {IDX_INTCTL, 8'h3C, 8'h3C}, {IDX_IRQ_MSK, 8'hFF, 8'h03}, {8'h55, 8'hFF, 8'h00}};
  logic             clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [ADR_W-1:0] adr_i = '0;
  logic [3:0]       sel_i = 4'h0;
  logic [3:0]       selw  = 4'hF;
  logic [31:0]      dat_i = 32'h0, dat_o;
  logic             ack_o, sleep = 1'b0, sysint = 1'b0, eck, gate = 1'b0, go = 1'b0, busy;
  logic             d5, d4, p5, p4, osc, wake, isr, irq;
  logic [7:0]       npul = 8'h00, rd;
  logic [15:0]      cnt, c0, ex;
  int               mismatches = 0, tests_run = 0;
  always #2.5 clk_i = ~clk_i;
  stc_timer stc_timer_i (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .sleep_i(sleep),
    .sys_clk_internal_i(sysint), .ext_count_clock_pin_i(eck), .gate_input_pin_i(gate),
    .port_a_pin_5_i(1'b1), .port_a_pin_4_i(1'b1), .port_a_direction_5_i(1'b0), .port_a_direction_4_i(1'b0),
    .port_a_direction_5_o(d5), .port_a_direction_4_o(d4), .port_a_pin_5_o(p5), .port_a_pin_4_o(p4),
    .crystal_osc_enable_o(osc), .wake_req_o(wake), .isr_branch_o(isr), .irq_o(irq));
  stc_pin_model stc_pin_model_i (.clk_i(clk_i), .go_i(go), .n_i(npul), .pin_o(eck), .busy_o(busy));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // classic cycle: hold everything until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= {idx, 2'b00};
    sel_i <= selw;
    dat_i <= {24'h0, wd};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 16);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (n >= 16) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic rcnt();
    wb(1'b0, IDX_CNT_LO, 8'h00);
    cnt[7:0] = rd;
    wb(1'b0, IDX_CNT_HI, 8'h00);
    cnt[15:8] = rd;
  endtask
  // stops the counter first, since a write racing an increment may leave the other byte stale
  task automatic wcnt(input logic [15:0] v);
    wb(1'b1, IDX_CTRL, 8'h00);
    wb(1'b1, IDX_CNT_LO, v[7:0]);
    wb(1'b1, IDX_CNT_HI, v[15:8]);
  endtask
  task automatic pulses(input logic [7:0] k);
    int n;
    n = 0;
    go   <= 1'b1;
    npul <= k;
    @(posedge clk_i);
    go <= 1'b0;
    do begin
      @(posedge clk_i);
      n++;
    end while (busy && n < 4000);
    repeat (8) @(posedge clk_i);
    if (n >= 4000) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wb(1'b1, ROWS[i][23:16], ROWS[i][15:8]);
      wb(1'b0, ROWS[i][23:16], 8'h00);
      chk("register", {8'h00, rd}, {8'h00, ROWS[i][7:0]});
    end
    $display("register table done");
    rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, ROWS[i][23:16], 8'h00);
      chk("reset value", {8'h00, rd}, 16'h0000);
    end
    selw = 4'hE;
    wb(1'b1, IDX_CNT_LO, 8'h33);
    selw = 4'hF;
    wb(1'b0, IDX_CNT_LO, 8'h00);
    chk("byte lane off", {8'h00, rd}, 16'h0000);
    $display("reset done");
    for (int p = 0; p < 4; p++) begin
      wcnt(16'h0000);
      wb(1'b1, IDX_CTRL, {2'b00, p[1:0], 4'h1});
      repeat (256) @(posedge clk_i);
      wb(1'b1, IDX_CTRL, 8'h00);
      rcnt();
      ex = 16'd259 >> (p + 2);
      chk("prescale", {15'h0, cnt + 16'h1 >= ex && cnt <= ex + 16'h1}, 16'h0001);
      c0 = cnt;
      repeat (40) @(posedge clk_i);
      rcnt();
      chk("held", cnt, c0);
    end
    $display("prescale done");
    gate <= 1'b1;
    wcnt(16'h0000);
    wb(1'b1, IDX_CTRL, 8'h41);
    repeat (100) @(posedge clk_i);
    rcnt();
    chk("gate closed", cnt, 16'h0000);
    gate <= 1'b0;
    repeat (100) @(posedge clk_i);
    rcnt();
    chk("gate open", {15'h0, cnt > 16'h0010}, 16'h0001);
    $display("gate done");
    wcnt(16'h0000);
    wb(1'b1, IDX_CTRL, 8'h07);
    sleep <= 1'b1;
    pulses(8'd10);
    sleep <= 1'b0;
    rcnt();
    chk("bypass in sleep", cnt, 16'd10);
    wcnt(16'h0000);
    wb(1'b1, IDX_CTRL, 8'h03);
    pulses(8'd5);
    rcnt();
    chk("synced count", cnt, 16'd5);
    sleep <= 1'b1;
    pulses(8'd3);
    sleep <= 1'b0;
    rcnt();
    chk("synced in sleep", cnt, 16'd5);
    $display("external done");
    wcnt(16'hFFFF);
    wb(1'b1, IDX_IRQ_MSK, 8'h03);
    wb(1'b1, IDX_PEN, 8'h01);
    wb(1'b1, IDX_INTCTL, 8'hC0);
    wb(1'b1, IDX_CTRL, 8'h07);
    sleep <= 1'b1;
    pulses(8'd1);
    chk("wake outputs", {13'h0, irq, wake, isr}, 16'h0007);
    sleep <= 1'b0;
    rcnt();
    chk("wrapped", cnt, 16'h0000);
    wb(1'b0, IDX_PFLAGS, 8'h00);
    chk("overflow flag", {8'h00, rd}, 16'h0001);
    wb(1'b0, IDX_IRQ_ST, 8'h00);
    chk("status", {8'h00, rd}, 16'h0003);
    wb(1'b1, IDX_IRQ_MSK, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("masked", {15'h0, irq}, 16'h0000);
    wb(1'b1, IDX_IRQ_ST, 8'h03);
    wb(1'b1, IDX_IRQ_MSK, 8'h03);
    repeat (2) @(posedge clk_i);
    chk("cleared", {15'h0, irq}, 16'h0000);
    wb(1'b1, IDX_INTCTL, 8'h40);
    repeat (2) @(posedge clk_i);
    chk("no branch", {14'h0, wake, isr}, 16'h0002);
    wb(1'b1, IDX_PFLAGS, 8'h00);
    repeat (2) @(posedge clk_i);
    chk("wake cleared", {15'h0, wake}, 16'h0000);
    wb(1'b1, IDX_CTRL, 8'h00);
    $display("overflow done");
    wb(1'b1, IDX_CTRL, 8'h08);
    repeat (4) @(posedge clk_i);
    chk("crystal blocked", {15'h0, osc}, 16'h0000);
    sysint <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk("crystal on", {11'h0, osc, d5, d4, p5, p4}, 16'h001C);
    repeat (40) @(posedge clk_i);
    wb(1'b1, IDX_CTRL, 8'h09);
    repeat (40) @(posedge clk_i);
    rcnt();
    chk("run after start-up", {15'h0, cnt > 16'h0005}, 16'h0001);
    wb(1'b1, IDX_CTRL, 8'h00);
    repeat (4) @(posedge clk_i);
    chk("crystal off", {11'h0, osc, d5, d4, p5, p4}, 16'h0003);
    $display("crystal done");
    report_and_stop();
  end
endmodule // stc_timer_bench
bind stc_timer stc_timer_checker stc_timer_checker_i (.*);
